// ---- src/pkt_cmd_pkg.sv ----
// Package with opcodes, field positions, sense codes and carrier types of the packet command decoder.
package pkt_cmd_pkg;
  localparam logic [7:0] OP_FLUSH    = 8'h35;
  localparam logic [7:0] OP_READY    = 8'h00;
  localparam logic [7:0] OP_VERIFY   = 8'h2F;
  localparam logic [7:0] OP_WRITE10  = 8'h2A;
  localparam logic [7:0] OP_WRITE12  = 8'hAA;
  localparam logic [7:0] OP_WRVERIFY = 8'h2E;
  localparam logic [7:0] OP_DOWNLOAD = 8'h3B;
  localparam logic [2:0] DL_MODE_OK  = 3'h5;
  localparam int IMMED_BIT    = 1;
  localparam int COMPARE_BIT  = 1;
  localparam int HOLD_BIT     = 5;
  localparam int PKT_BYTES    = 12;
  localparam logic [3:0] SK_NONE    = 4'h0;
  localparam logic [3:0] SK_NOT_RDY = 4'h2;
  localparam logic [3:0] SK_MEDIUM  = 4'h3;
  localparam logic [3:0] SK_HW      = 4'h4;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE      = 8'h00;
  localparam logic [7:0] ASC_BAD_OP    = 8'h20;
  localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
  localparam logic [7:0] ASC_NOT_RDY   = 8'h3A;
  localparam logic [7:0] ASC_WRITE_ERR = 8'h0C;
  localparam logic [7:0] ASC_INTERNAL  = 8'h44;
  localparam logic [7:0] ASCQ_ZERO     = 8'h00;
  localparam logic [3:0] PKT_IDX_RESET = 4'h0;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_SYNC  = 3'h1,
    OP_VER   = 3'h2,
    OP_WRITE = 3'h3,
    OP_DLOAD = 3'h4
  } media_op_type;

  typedef enum logic [2:0] {
    ST_COLLECT  = 3'h0,
    ST_DECODE   = 3'h1,
    ST_DATA     = 3'h2,
    ST_MEDIA    = 3'h3,
    ST_COMPLETE = 3'h4
  } state_type;

  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } sense_type;

  typedef struct packed {
    media_op_type op;
    logic [31:0]  lba;
    logic [31:0]  count;
    logic         verify_after;
    logic [3:0]   microcode_type_selector;
  } media_req_type;

  typedef struct packed {
    logic [23:0] offset;
    logic [7:0]  data;
  } buf_wr_type;
endpackage : pkt_cmd_pkg

// ---- src/pkt_cmd_decoder.sv ----
// Packet command decoder for flush, readiness, verify, write and firmware download commands.
`timescale 1ns/10ps
module pkt_cmd_decoder (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       pkt_valid_i,
  input  wire logic [7:0]                 pkt_byte_i,
  input  wire logic                       unit_ready_i,
  input  wire logic                       data_valid_i,
  input  wire logic [7:0]                 data_byte_i,
  input  wire logic                       media_done_i,
  input  wire logic                       media_fail_i,
  output logic                            data_req_o,
  output logic                            buf_wr_valid_o,
  output pkt_cmd_pkg::buf_wr_type         buf_wr_o,
  output logic                            media_start_o,
  output pkt_cmd_pkg::media_req_type      media_req_o,
  output logic                            busy_o,
  output logic                            done_o,
  output logic                            check_cond_o,
  output pkt_cmd_pkg::sense_type          sense_o
);

  typedef struct packed {
    pkt_cmd_pkg::state_type     st;
    logic [3:0]                 idx;
    logic [11:0][7:0]           pkt;
    logic [31:0]                data_left;
    logic [23:0]                buf_ptr;
    logic                       data_req;
    logic                       buf_wr_valid;
    pkt_cmd_pkg::buf_wr_type    buf_wr;
    logic                       media_start;
    pkt_cmd_pkg::media_req_type media_req;
    logic                       busy;
    logic                       done;
    logic                       check_cond;
    pkt_cmd_pkg::sense_type     sense;
  } regs_type;

  regs_type r_q;
  regs_type r_d;

  function automatic logic [31:0] be32(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] c, input logic [7:0] d);
    be32 = {a, b, c, d};
  endfunction : be32

  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.buf_wr_valid = 1'b0;
    r_d.media_start = 1'b0;
    unique case (r_q.st)
      pkt_cmd_pkg::ST_COLLECT: begin
        r_d.busy = (r_q.idx != pkt_cmd_pkg::PKT_IDX_RESET);
        if (pkt_valid_i) begin
          r_d.pkt[r_q.idx] = pkt_byte_i;
          r_d.busy = 1'b1;
          if (r_q.idx == 4'(pkt_cmd_pkg::PKT_BYTES - 1)) begin
            r_d.idx = pkt_cmd_pkg::PKT_IDX_RESET;
            r_d.st = pkt_cmd_pkg::ST_DECODE;
          end else begin
            r_d.idx = r_q.idx + 4'h1;
          end
        end
      end
      pkt_cmd_pkg::ST_DECODE: begin
        r_d.check_cond = 1'b0;
        r_d.sense = '{pkt_cmd_pkg::SK_NONE, pkt_cmd_pkg::ASC_NONE, pkt_cmd_pkg::ASCQ_ZERO};
        r_d.media_req.lba = be32(r_q.pkt[2], r_q.pkt[3], r_q.pkt[4], r_q.pkt[5]);
        r_d.media_req.count = {16'h0000, r_q.pkt[7], r_q.pkt[8]};
        r_d.media_req.verify_after = 1'b0;
        r_d.media_req.microcode_type_selector = 4'h0;
        r_d.st = pkt_cmd_pkg::ST_COMPLETE;
        unique case (r_q.pkt[0])
          pkt_cmd_pkg::OP_FLUSH: begin
            if (r_q.pkt[1][pkt_cmd_pkg::IMMED_BIT]) begin
              r_d.check_cond = 1'b1;
              r_d.sense = '{pkt_cmd_pkg::SK_ILLEGAL, pkt_cmd_pkg::ASC_BAD_FIELD,
                            pkt_cmd_pkg::ASCQ_ZERO};
            end else begin
              r_d.media_req.op = pkt_cmd_pkg::OP_SYNC;
              r_d.media_req.lba = 32'h0000_0000;
              r_d.media_req.count = 32'h0000_0000;
              r_d.media_start = 1'b1;
              r_d.st = pkt_cmd_pkg::ST_MEDIA;
            end
          end
          pkt_cmd_pkg::OP_READY: begin
            if (!unit_ready_i) begin
              r_d.check_cond = 1'b1;
              r_d.sense = '{pkt_cmd_pkg::SK_NOT_RDY, pkt_cmd_pkg::ASC_NOT_RDY,
                            pkt_cmd_pkg::ASCQ_ZERO};
            end
          end
          pkt_cmd_pkg::OP_VERIFY, pkt_cmd_pkg::OP_WRITE10, pkt_cmd_pkg::OP_WRVERIFY,
          pkt_cmd_pkg::OP_WRITE12: begin
            if (r_q.pkt[0] == pkt_cmd_pkg::OP_WRITE12) begin
              r_d.media_req.count = be32(r_q.pkt[6], r_q.pkt[7], r_q.pkt[8], r_q.pkt[9]);
            end
            if ((r_q.pkt[0] == pkt_cmd_pkg::OP_VERIFY || r_q.pkt[0] == pkt_cmd_pkg::OP_WRVERIFY)
                && r_q.pkt[1][pkt_cmd_pkg::COMPARE_BIT]) begin
              r_d.check_cond = 1'b1;
              r_d.sense = '{pkt_cmd_pkg::SK_ILLEGAL, pkt_cmd_pkg::ASC_BAD_FIELD,
                            pkt_cmd_pkg::ASCQ_ZERO};
            end else if (r_d.media_req.count == 32'h0000_0000) begin
              r_d.st = pkt_cmd_pkg::ST_COMPLETE;
            end else if (r_q.pkt[0] == pkt_cmd_pkg::OP_VERIFY) begin
              r_d.media_req.op = pkt_cmd_pkg::OP_VER;
              r_d.media_start = 1'b1;
              r_d.st = pkt_cmd_pkg::ST_MEDIA;
            end else begin
              r_d.media_req.op = pkt_cmd_pkg::OP_WRITE;
              r_d.media_req.verify_after = (r_q.pkt[0] == pkt_cmd_pkg::OP_WRVERIFY);
              r_d.media_start = 1'b1;
              r_d.data_left = r_d.media_req.count;
              r_d.buf_ptr = 24'h00_0000;
              r_d.st = pkt_cmd_pkg::ST_DATA;
            end
          end
          pkt_cmd_pkg::OP_DOWNLOAD: begin
            r_d.media_req.microcode_type_selector = r_q.pkt[2][3:0];
            r_d.buf_ptr = {r_q.pkt[3], r_q.pkt[4], r_q.pkt[5]};
            r_d.data_left = {8'h00, r_q.pkt[6], r_q.pkt[7], r_q.pkt[8]};
            r_d.media_req.lba = 32'h0000_0000;
            r_d.media_req.count = {8'h00, r_q.pkt[6], r_q.pkt[7], r_q.pkt[8]};
            r_d.media_req.op = pkt_cmd_pkg::OP_DLOAD;
            if (r_q.pkt[1][2:0] != pkt_cmd_pkg::DL_MODE_OK) begin
              r_d.check_cond = 1'b1;
              r_d.sense = '{pkt_cmd_pkg::SK_ILLEGAL, pkt_cmd_pkg::ASC_BAD_FIELD,
                            pkt_cmd_pkg::ASCQ_ZERO};
            end else if (r_d.data_left != 32'h0000_0000) begin
              r_d.st = pkt_cmd_pkg::ST_DATA;
            end else if (!r_q.pkt[2][pkt_cmd_pkg::HOLD_BIT]) begin
              r_d.media_start = 1'b1;
              r_d.st = pkt_cmd_pkg::ST_MEDIA;
            end
          end
          default: begin
            r_d.check_cond = 1'b1;
            r_d.sense = '{pkt_cmd_pkg::SK_ILLEGAL, pkt_cmd_pkg::ASC_BAD_OP,
                          pkt_cmd_pkg::ASCQ_ZERO};
          end
        endcase
      end
      pkt_cmd_pkg::ST_DATA: begin
        r_d.data_req = 1'b1;
        if (r_q.media_req.op == pkt_cmd_pkg::OP_WRITE && (media_done_i || media_fail_i)) begin
          r_d.data_req = 1'b0;
          r_d.check_cond = media_fail_i;
          if (media_fail_i) begin
            r_d.sense = '{pkt_cmd_pkg::SK_MEDIUM, pkt_cmd_pkg::ASC_WRITE_ERR,
                          pkt_cmd_pkg::ASCQ_ZERO};
          end
          r_d.st = pkt_cmd_pkg::ST_COMPLETE;
        end else if (r_q.media_req.op == pkt_cmd_pkg::OP_DLOAD && data_valid_i
                     && r_q.data_req) begin
          r_d.buf_wr_valid = 1'b1;
          r_d.buf_wr = '{r_q.buf_ptr, data_byte_i};
          r_d.buf_ptr = r_q.buf_ptr + 24'h00_0001;
          r_d.data_left = r_q.data_left - 32'h0000_0001;
          if (r_q.data_left == 32'h0000_0001) begin
            r_d.data_req = 1'b0;
            if (r_q.pkt[2][pkt_cmd_pkg::HOLD_BIT]) begin
              r_d.st = pkt_cmd_pkg::ST_COMPLETE;
            end else begin
              r_d.media_start = 1'b1;
              r_d.st = pkt_cmd_pkg::ST_MEDIA;
            end
          end
        end
      end
      pkt_cmd_pkg::ST_MEDIA: begin
        if (media_done_i || media_fail_i) begin
          r_d.check_cond = media_fail_i;
          if (media_fail_i) begin
            r_d.sense = '{pkt_cmd_pkg::SK_HW, pkt_cmd_pkg::ASC_INTERNAL,
                          pkt_cmd_pkg::ASCQ_ZERO};
          end
          r_d.st = pkt_cmd_pkg::ST_COMPLETE;
        end
      end
      pkt_cmd_pkg::ST_COMPLETE: begin
        r_d.done = 1'b1;
        r_d.busy = 1'b0;
        r_d.st = pkt_cmd_pkg::ST_COLLECT;
      end
      default: begin
        r_d.st = pkt_cmd_pkg::ST_COLLECT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign data_req_o     = r_q.data_req;
  assign buf_wr_valid_o = r_q.buf_wr_valid;
  assign buf_wr_o       = r_q.buf_wr;
  assign media_start_o  = r_q.media_start;
  assign media_req_o    = r_q.media_req;
  assign busy_o         = r_q.busy;
  assign done_o         = r_q.done;
  assign check_cond_o   = r_q.check_cond;
  assign sense_o        = r_q.sense;

endmodule : pkt_cmd_decoder

// ---- bench/pkt_cmd_decoder_asserts.sv ----
// Checker of decoder status and timing at the top module ports.
`timescale 1ns/10ps
module pkt_cmd_decoder_asserts (
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   pkt_valid_i,
  input wire logic [7:0]             pkt_byte_i,
  input wire logic                   unit_ready_i,
  input wire logic                   data_valid_i,
  input wire logic                   media_done_i,
  input wire logic                   media_fail_i,
  input wire logic                   data_req_o,
  input wire logic                   buf_wr_valid_o,
  input wire logic                   media_start_o,
  input wire logic                   done_o,
  input wire logic                   check_cond_o,
  input wire pkt_cmd_pkg::sense_type sense_o
);
  localparam logic [19:0] BAD_FLD = {pkt_cmd_pkg::SK_ILLEGAL, pkt_cmd_pkg::ASC_BAD_FIELD, 8'h00};
  logic [3:0] cnt_q;
  logic [7:0] op_q;
  logic [7:0] b1_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || done_o) cnt_q <= 4'h0;
    else if (pkt_valid_i) cnt_q <= cnt_q + 4'h1;
    if (pkt_valid_i && cnt_q == 4'h0) op_q <= pkt_byte_i;
    if (pkt_valid_i && cnt_q == 4'h1) b1_q <= pkt_byte_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_ready_status: assert property (
    done_o && op_q == 8'h00 |-> check_cond_o == !unit_ready_i) else $error("ready status wrong");
  a_flush_immed: assert property (
    done_o && op_q == 8'h35 && b1_q[1] |-> check_cond_o) else $error("flush immediate accepted");
  a_compare_flag: assert property (
    done_o && (op_q == 8'h2F || op_q == 8'h2E) && b1_q[1] |-> check_cond_o && sense_o == BAD_FLD)
    else $error("compare flag accepted");
  a_mode_check: assert property (
    done_o && op_q == 8'h3B && b1_q[2:0] != 3'h5 |-> check_cond_o && sense_o == BAD_FLD)
    else $error("bad download mode accepted");
  a_decode_time: assert property (
    pkt_valid_i && cnt_q == 4'hB && op_q == 8'h00 |-> ##3 done_o) else $error("decode late");
  a_start_pulse: assert property (
    media_start_o |=> !media_start_o ##1 !media_start_o) else $error("start not a pulse");
  a_media_end: assert property (
    media_done_i |-> ##2 (done_o && !check_cond_o)) else $error("done not after media");
  a_fail_check: assert property (
    media_fail_i |-> ##2 (done_o && check_cond_o)) else $error("failure not reported");
  a_buf_gate: assert property (
    buf_wr_valid_o |-> $past(data_valid_i) && $past(data_req_o)) else $error("buffer write unasked");
endmodule : pkt_cmd_decoder_asserts
bind pkt_cmd_decoder pkt_cmd_decoder_asserts u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .pkt_valid_i(pkt_valid_i), .pkt_byte_i(pkt_byte_i), .unit_ready_i(unit_ready_i),
  .data_valid_i(data_valid_i), .media_done_i(media_done_i), .media_fail_i(media_fail_i),
  .data_req_o(data_req_o), .buf_wr_valid_o(buf_wr_valid_o), .media_start_o(media_start_o),
  .done_o(done_o), .check_cond_o(check_cond_o), .sense_o(sense_o));

// ---- bench/media_model.sv ----
// Behavioural media path and flash programmer answering start pulses.
`timescale 1ns/10ps
module media_model (
  input  wire logic clk_i,
  input  wire logic start_i,
  input  wire logic fail_en_i,
  output logic      done_o = 1'b0,
  output logic      fail_o = 1'b0
);
  int cnt = 0;
  always @(negedge clk_i) begin
    done_o <= 1'b0;
    fail_o <= 1'b0;
    if (start_i) cnt <= 5;
    else if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      done_o <= !fail_en_i;
      fail_o <= fail_en_i;
    end
  end
endmodule : media_model

// ---- bench/test_pkt_cmd_decoder.sv ----
// Self-checking bench for the packet command decoder.
`timescale 1ns/10ps
module test_pkt_cmd_decoder;
  logic clk_i = 0, sys_rst_i = 1, pkt_valid_i = 0, unit_ready_i = 1, data_valid_i = 0;
  logic [7:0] pkt_byte_i = 8'h00, data_byte_i = 8'h00;
  logic media_done_i, media_fail_i, fail_en = 0;
  logic data_req_o, buf_wr_valid_o, media_start_o, busy_o, done_o, check_cond_o;
  pkt_cmd_pkg::buf_wr_type buf_wr_o;
  pkt_cmd_pkg::media_req_type media_req_o;
  pkt_cmd_pkg::sense_type sense_o;
  int errors = 0, n_checks = 0, starts = 0, nbuf = 0;
  logic [23:0] first_off;
  pkt_cmd_decoder DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pkt_valid_i(pkt_valid_i),
    .pkt_byte_i(pkt_byte_i), .unit_ready_i(unit_ready_i), .data_valid_i(data_valid_i),
    .data_byte_i(data_byte_i), .media_done_i(media_done_i), .media_fail_i(media_fail_i),
    .data_req_o(data_req_o), .buf_wr_valid_o(buf_wr_valid_o), .buf_wr_o(buf_wr_o),
    .media_start_o(media_start_o), .media_req_o(media_req_o), .busy_o(busy_o),
    .done_o(done_o), .check_cond_o(check_cond_o), .sense_o(sense_o));
  media_model u_media (.clk_i(clk_i), .start_i(media_start_o), .fail_en_i(fail_en),
    .done_o(media_done_i), .fail_o(media_fail_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    if (media_start_o === 1'b1) starts++;
    if (buf_wr_valid_o === 1'b1) begin
      if (nbuf == 0) first_off = buf_wr_o.offset;
      chk("buf_data", buf_wr_o.data, data_byte_i);
      chk("buf_off", buf_wr_o.offset, first_off + 24'(nbuf));
      nbuf++;
    end
  end
  always @(negedge clk_i) begin
    data_valid_i <= data_req_o;
    data_byte_i <= data_byte_i + 8'h01;
  end
  task automatic chk(input string nm, input logic [73:0] seen, input logic [73:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input logic [95:0] p, input logic ec, input int es);
    int w;
    starts = 0;
    nbuf = 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_i);
      pkt_valid_i = 1'b1;
      pkt_byte_i = p[95 - 8 * i -: 8];
    end
    @(negedge clk_i);
    pkt_valid_i = 1'b0;
    chk("busy_on", busy_o, 1'b1);
    w = 0;
    while (done_o !== 1'b1 && w < 3000) begin
      @(negedge clk_i);
      w++;
    end
    chk("done", done_o, 1'b1);
    chk("check", check_cond_o, ec);
    chk("starts", starts, es);
    repeat (3) @(negedge clk_i);
    chk("busy", busy_o, 1'b0);
    chk("data_req", data_req_o, 1'b0);
  endtask : run
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk("reset", {busy_o, done_o, check_cond_o, data_req_o, media_start_o, buf_wr_valid_o},
        6'h00);
    run({8'h00, 88'h0}, 1'b0, 0);
    unit_ready_i = 1'b0;
    run({8'h00, 88'h0}, 1'b1, 0);
    unit_ready_i = 1'b1;
    run({8'h35, 8'h00, 32'hFFFFFFFF, 8'h00, 16'hFFFF, 24'h0}, 1'b0, 1);
    chk("op", media_req_o.op, pkt_cmd_pkg::OP_SYNC);
    run({8'h35, 8'h02, 80'h0}, 1'b1, 0);
    chk("sense", sense_o, 20'h52400);
    run({8'h2F, 8'h00, 32'h01020304, 8'h00, 16'h0005, 24'h0}, 1'b0, 1);
    chk("lba", media_req_o.lba, 32'h01020304);
    chk("count", media_req_o.count, 32'h5);
    run({8'h2F, 8'h00, 32'h01020304, 8'h00, 16'h0000, 24'h0}, 1'b0, 0);
    run({8'h2F, 8'h02, 32'h01020304, 8'h00, 16'h0005, 24'h0}, 1'b1, 0);
    run({8'h2E, 8'h02, 32'h00000001, 8'h00, 16'h0002, 24'h0}, 1'b1, 0);
    run({8'h2A, 8'h00, 32'h0A0B0C0D, 8'h00, 16'h0102, 24'h0}, 1'b0, 1);
    chk("wr10", media_req_o, {pkt_cmd_pkg::OP_WRITE, 64'h0A0B0C0D00000102, 5'h0});
    run({8'hAA, 8'h00, 32'h11223344, 32'h00010203, 16'h0}, 1'b0, 1);
    chk("count12", media_req_o.count, 32'h00010203);
    run({8'h2E, 8'h00, 32'h00000005, 8'h00, 16'h0003, 24'h0}, 1'b0, 1);
    chk("wrv", media_req_o, {pkt_cmd_pkg::OP_WRITE, 64'h0000000500000003, 5'h10});
    run({8'h2A, 88'h0}, 1'b0, 0);
    run({8'hAA, 88'h0}, 1'b0, 0);
    run({8'h2E, 88'h0}, 1'b0, 0);
    run({8'h3B, 8'h05, 8'h23, 24'h000040, 24'h000004, 24'h0}, 1'b0, 0);
    chk("nbuf", nbuf, 4);
    chk("offset", first_off, 24'h000040);
    run({8'h3B, 8'h05, 8'h00, 24'h0, 24'h000002, 24'h0}, 1'b0, 1);
    chk("nbuf", nbuf, 2);
    chk("offset", first_off, 24'h000000);
    run({8'h3B, 8'h05, 8'h20, 72'h0}, 1'b0, 0);
    chk("nbuf", nbuf, 0);
    run({8'h3B, 8'h05, 8'h02, 72'h0}, 1'b0, 1);
    chk("dl", {media_req_o.op, media_req_o.microcode_type_selector}, 7'h42);
    for (int m = 0; m < 8; m++) begin
      if (m != 5) run({8'h3B, 5'h0, 3'(m), 80'h0}, 1'b1, 0);
    end
    fail_en = 1'b1;
    run({8'h3B, 8'h05, 80'h0}, 1'b1, 1);
    chk("sense", sense_o, 20'h44400);
    run({8'h2A, 8'h00, 32'h00000001, 8'h00, 16'h0001, 24'h0}, 1'b1, 1);
    chk("sense", sense_o, 20'h30C00);
    fail_en = 1'b0;
    run({8'h12, 88'h0}, 1'b1, 0);
    chk("sense", sense_o, 20'h52000);
    finish_test();
  end
endmodule : test_pkt_cmd_decoder
